// ==== cdo_output.sv ====
// Audio serial, digital audio and subcode output stage of a disc decoder.
// Assumes samples and subcode come from logic on mclk; read clock pin is
// asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "cdo_params.svh"
module cdo_output (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Decoder side
  input wire cdo_pkg::cdo_cfg_t cfg,
  input wire cdo_pkg::cdo_sample_t sample_in,
  output logic sample_take,
  input wire cdo_pkg::cdo_subcode_t sub_in,
  // Interrupt to the controller
  output logic cd_irq,
  output logic [3:0] cd_irq_vector,
  // Pins shared with the general port
  input wire logic [`CDO_NPINS-1:0] pin_func_sel,
  input wire logic [`CDO_NPINS-1:0] port_out,
  input wire logic [`CDO_NPINS-1:0] port_oe,
  input wire logic [`CDO_NPINS-1:0] pin_in,
  output logic [`CDO_NPINS-1:0] pin_out,
  output logic [`CDO_NPINS-1:0] pin_oe
);
  import cdo_pkg::*;

  function automatic logic [6:0] bits_per_frame(input logic [1:0] sel);
    case (sel)
      `CDO_SEL_48: bits_per_frame = `CDO_BITS_48;
      `CDO_SEL_64: bits_per_frame = `CDO_BITS_64;
      default: bits_per_frame = `CDO_BITS_32;
    endcase
  endfunction : bits_per_frame

  // Phase step for two bit-clock toggles per bit, fs doubled at 2x
  function automatic logic [31:0] nco_step(input logic [1:0] sel,
                                           input logic dbl);
    logic [63:0] r;
    r = 64'd2 * {57'h0, bits_per_frame(sel)} * `CDO_FS_HZ;
    if (dbl) r = r * 64'd2;
    nco_step = 32'((r * `CDO_NCO_ONE) / `CDO_MCLK_HZ);
  endfunction : nco_step

  // Audio group
  logic [31:0] nco_reg, nco_next;
  logic bck_reg, bck_next;
  logic [6:0] idx_reg, idx_next;
  cdo_sample_t smp_reg, smp_next;
  logic channel_select_clock_reg, channel_select_clock_next;
  logic serial_audio_out_reg, serial_audio_out_next;
  logic unc_reg, unc_next;
  logic dout_reg, dout_next;
  logic take_reg, take_next;
  logic nco_carry, bck_fall, bck_rise;
  logic [6:0] half, pos;
  logic right_ch, cur_bit, cur_bad;

  always_comb begin
    {nco_carry, nco_next} = {1'b0, nco_reg} +
                            {1'b0, nco_step(cfg.bck_sel, cfg.double_speed)};
    bck_next = bck_reg ^ nco_carry; // [R1] [R2]
    bck_fall = nco_carry && bck_reg;
    bck_rise = nco_carry && !bck_reg;
    half = bits_per_frame(cfg.bck_sel) >> 1;
    idx_next = idx_reg;
    smp_next = smp_reg;
    take_next = 1'b0;
    if (bck_fall) begin
      if (idx_reg + 7'h1 >= bits_per_frame(cfg.bck_sel)) begin
        idx_next = 7'h0; // [R5]
        smp_next = sample_in;
        take_next = 1'b1;
      end else begin
        idx_next = idx_reg + 7'h1;
      end
    end
    right_ch = idx_next >= half;
    pos = right_ch ? idx_next - half : idx_next;
    cur_bit = 1'b0;
    if (pos < `CDO_SAMPLE_BITS) begin
      if (cfg.lsb_first) // [R6]
        cur_bit = right_ch ? smp_next.right[pos[3:0]] :
                             smp_next.left[pos[3:0]];
      else
        cur_bit = right_ch ? smp_next.right[4'hf - pos[3:0]] :
                             smp_next.left[4'hf - pos[3:0]];
    end
    cur_bad = smp_next.c2_mode &&
              (right_ch ? smp_next.right_bad : smp_next.left_bad);
    channel_select_clock_next = channel_select_clock_reg;
    serial_audio_out_next = serial_audio_out_reg;
    unc_next = unc_reg;
    if (bck_fall) begin // [R17]
      channel_select_clock_next = right_ch ^ cfg.lr_invert; // [R3] [R4]
      serial_audio_out_next = cur_bit;
      unc_next = cur_bad; // [R8]
    end
    // Biphase mark: a cell per bit, mid-cell toggle for a one
    dout_next = dout_reg;
    if (bck_fall)
      dout_next = ~dout_reg; // [R7]
    else if (bck_rise && serial_audio_out_reg)
      dout_next = ~dout_reg; // [R7]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nco_reg <= 32'h0;
      bck_reg <= 1'b0;
      idx_reg <= 7'h0;
      smp_reg <= '0;
      channel_select_clock_reg <= 1'b0;
      serial_audio_out_reg <= 1'b0;
      unc_reg <= 1'b0;
      dout_reg <= 1'b0;
      take_reg <= 1'b0;
    end else begin
      nco_reg <= nco_next;
      bck_reg <= bck_next;
      idx_reg <= idx_next;
      smp_reg <= smp_next;
      channel_select_clock_reg <= channel_select_clock_next;
      serial_audio_out_reg <= serial_audio_out_next;
      unc_reg <= unc_next;
      dout_reg <= dout_next;
      take_reg <= take_next;
    end
  end

  // Read clock pin, two-flop synchroniser then edge detect
  logic rs1_reg, rs2_reg, rs3_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
      rs3_reg <= 1'b0;
    end else begin
      rs1_reg <= pin_in[`CDO_PIN_RCLK];
      rs2_reg <= rs1_reg;
      rs3_reg <= rs2_reg;
    end
  end

  // Subcode group
  logic [6:0] fidx_reg, fidx_next;
  logic found_reg, found_next;
  logic [15:0] crc_reg, crc_next;
  logic qok_reg, qok_next;
  logic bsyn_reg, bsyn_next;
  logic irq_reg, irq_next;
  logic [9:0] fsc_reg, fsc_next;
  logic fsyn_reg, fsyn_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] sbit_reg, sbit_next;
  logic [9:0] rdiv_reg, rdiv_next;
  logic rclk_reg, rclk_next;
  logic sdat_reg, sdat_next;
  logic sub_adv, qbit, fb;

  always_comb begin
    fidx_next = fidx_reg;
    found_next = found_reg;
    crc_next = crc_reg;
    qok_next = qok_reg;
    fsc_next = (fsc_reg != 10'h0) ? fsc_reg - 10'h1 : 10'h0;
    qbit = 1'b0;
    fb = 1'b0;
    if (sub_in.frame_strobe) begin
      fsc_next = `CDO_SYNC_CYC; // [R12]
      if (sub_in.block_sync) begin
        fidx_next = 7'h0;
        found_next = 1'b1;
        crc_next = 16'h0;
      end else if (fidx_reg < `CDO_LAST_FRAME) begin
        fidx_next = fidx_reg + 7'h1;
      end
      if (!sub_in.block_sync && fidx_next >= `CDO_FIRST_Q &&
          fidx_reg < `CDO_LAST_FRAME) begin
        // Parity travels inverted on disc, undo so a good block leaves zero
        qbit = sub_in.pw[`CDO_Q_BIT] ^ (fidx_next >= `CDO_FIRST_CRC);
        fb = crc_reg[15] ^ qbit;
        crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? `CDO_CRC_POLY : 16'h0);
        if (fidx_next == `CDO_LAST_FRAME)
          qok_next = (crc_next == 16'h0); // [R9]
      end
    end
    fsyn_next = fsc_next != 10'h0;
    bsyn_next = found_next && fidx_next == `CDO_S1_FRAME; // [R13]
    irq_next = cfg.irq_en && bsyn_reg && !bsyn_next; // [R14] [R15]
    // Read clock: driven here in output mode, sampled in input mode
    rdiv_next = rdiv_reg;
    rclk_next = rclk_reg;
    sub_adv = 1'b0;
    if (cfg.rclk_is_input) begin // [R10]
      rclk_next = 1'b0;
      sub_adv = (rs2_reg ^ cfg.rclk_invert) && !(rs3_reg ^ cfg.rclk_invert);
    end else if (sbit_reg != 4'h0 && !sub_in.frame_strobe) begin
      if (rdiv_reg == 10'h0) begin
        rdiv_next = `CDO_RCLK_CYC - 10'h1;
        rclk_next = ~rclk_reg;
        sub_adv = rclk_reg;
      end else begin
        rdiv_next = rdiv_reg - 10'h1;
      end
    end else begin
      rdiv_next = `CDO_RCLK_CYC - 10'h1;
      rclk_next = 1'b0;
    end
    sh_next = sh_reg;
    sbit_next = sbit_reg;
    if (sub_in.frame_strobe) begin
      sh_next = sub_in.pw;
      sbit_next = 4'h8;
    end else if (sub_adv && sbit_reg != 4'h0) begin
      sh_next = {sh_reg[6:0], 1'b0}; // [R11]
      sbit_next = sbit_reg - 4'h1;
    end
    sdat_next = sh_next[7];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fidx_reg <= 7'h0;
      found_reg <= 1'b0;
      crc_reg <= 16'h0;
      qok_reg <= 1'b0;
      bsyn_reg <= 1'b0;
      irq_reg <= 1'b0;
      fsc_reg <= 10'h0;
      fsyn_reg <= 1'b0;
      sh_reg <= 8'h0;
      sbit_reg <= 4'h0;
      rdiv_reg <= 10'h0;
      rclk_reg <= 1'b0;
      sdat_reg <= 1'b0;
    end else begin
      fidx_reg <= fidx_next;
      found_reg <= found_next;
      crc_reg <= crc_next;
      qok_reg <= qok_next;
      bsyn_reg <= bsyn_next;
      irq_reg <= irq_next;
      fsc_reg <= fsc_next;
      fsyn_reg <= fsyn_next;
      sh_reg <= sh_next;
      sbit_reg <= sbit_next;
      rdiv_reg <= rdiv_next;
      rclk_reg <= rclk_next;
      sdat_reg <= sdat_next;
    end
  end

  // Pin multiplexer, registered so every pin comes from a flop
  logic [`CDO_NPINS-1:0] func_val, func_oe, pout_next, poe_next;
  always_comb begin
    func_val = '0;
    func_val[`CDO_PIN_BCK] = bck_next;
    func_val[`CDO_PIN_CHANNEL_SELECT_CLOCK] = channel_select_clock_next;
    func_val[`CDO_PIN_SERIAL_AUDIO_OUT] = serial_audio_out_next;
    func_val[`CDO_PIN_DOUT] = dout_next;
    func_val[`CDO_PIN_UNC] = unc_next;
    func_val[`CDO_PIN_QOK] = qok_next;
    func_val[`CDO_PIN_RCLK] = rclk_next ^ cfg.rclk_invert;
    func_val[`CDO_PIN_SDAT] = sdat_next;
    func_val[`CDO_PIN_FSYN] = fsyn_next;
    func_val[`CDO_PIN_BSYN] = bsyn_next;
    func_oe = '1;
    func_oe[`CDO_PIN_RCLK] = !cfg.rclk_is_input; // [R10]
    for (int i = 0; i < `CDO_NPINS; i++) begin
      pout_next[i] = pin_func_sel[i] ? func_val[i] : port_out[i]; // [R16]
      poe_next[i] = pin_func_sel[i] ? func_oe[i] : port_oe[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
      pin_oe <= '0;
      cd_irq_vector <= 4'h0;
    end else begin
      pin_out <= pout_next;
      pin_oe <= poe_next;
      cd_irq_vector <= `CDO_IRQ_VECTOR; // [R14]
    end
  end

  assign sample_take = take_reg;
  assign cd_irq = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  bck_on_carry_a: assert property ( // [R1]
    $changed(bck_reg) |-> $past(nco_carry))
    else $error("bit clock moved without phase carry");
  channel_select_clock_on_fall_a: assert property ( // [R17]
    $changed(channel_select_clock_reg) || $changed(serial_audio_out_reg) |-> $past(bck_fall))
    else $error("audio output moved off falling bit clock");
  frame_wrap_a: assert property ( // [R5]
    bck_fall && idx_next == 7'h0 |=> take_reg && channel_select_clock_reg == cfg.lr_invert)
    else $error("frame wrap did not start left channel");
  lr_polarity_a: assert property ( // [R3]
    bck_fall |=> channel_select_clock_reg == ((idx_reg >= half) ^ cfg.lr_invert))
    else $error("channel clock polarity wrong");
  unc_flag_a: assert property ( // [R8]
    unc_reg |-> smp_reg.c2_mode)
    else $error("uncorrectable flag outside C2 mode");
  dout_carry_a: assert property ( // [R7]
    $changed(dout_reg) |-> $past(nco_carry))
    else $error("digital output moved off cell edge");
  qok_update_a: assert property ( // [R9]
    $changed(qok_reg) |-> $past(sub_in.frame_strobe && fidx_next ==
                                `CDO_LAST_FRAME))
    else $error("crc flag changed outside block end");
  bsync_s1_a: assert property ( // [R13]
    bsyn_reg |-> fidx_reg == `CDO_S1_FRAME && found_reg)
    else $error("block sync outside S1");
  irq_fall_a: assert property ( // [R14]
    irq_reg |-> $past(bsyn_reg) && !bsyn_reg && $past(cfg.irq_en))
    else $error("interrupt without block sync fall");
  fsync_rise_a: assert property ( // [R12]
    $rose(fsyn_reg) |-> $past(sub_in.frame_strobe))
    else $error("frame sync without subcode frame");
  sub_shift_a: assert property ( // [R11]
    $changed(sh_reg) |-> $past(sub_adv || sub_in.frame_strobe))
    else $error("subcode shifted without read clock");
endmodule : cdo_output
`default_nettype wire

// ==== cdo_params.svh ====
// Constants for the disc audio and subcode output block.
// Assumes a single 100 MHz clock and 16-bit decoded samples.
// How it works
// [R1] Bit clock 32, 48 or 64 times fs
// [R2] 32x at normal speed gives 1.4112 MHz
// [R3] Channel clock low left, high right
// [R4] Command inverts channel clock polarity
// [R5] Channel clock period is 44.1 kHz at normal speed, 88.2 kHz at double speed
// [R6] Audio data MSB or LSB first
// [R7] Digital audio output works to double speed
// [R8] Flag high for uncorrectable C2 symbols
// [R9] Q-channel CRC pass flag
// [R10] Read clock input or output, polarity selectable
// [R11] P to W shifted out by read clock
// [R12] Frame sync pulse each subcode frame
// [R13] Block sync high at S1 frame
// [R14] Block sync falling edge raises interrupt, vector 2
// [R15] Software keeps interrupt off while undefined
// [R16] Each pin selectable as port or function
// [R17] Outputs change on falling bit-clock edge; DOUT also toggles on the rising edge, mid-cell, for a one bit
`ifndef CDO_PARAMS_SVH
`define CDO_PARAMS_SVH
`define CDO_MCLK_HZ 64'd100000000
`define CDO_FS_HZ 64'd44100
`define CDO_NCO_ONE 64'h100000000
`define CDO_SEL_32 2'h0
`define CDO_SEL_48 2'h1
`define CDO_SEL_64 2'h2
`define CDO_BITS_32 7'h20
`define CDO_BITS_48 7'h30
`define CDO_BITS_64 7'h40
`define CDO_SAMPLE_BITS 7'h10
`define CDO_IRQ_VECTOR 4'h2
`define CDO_FRAMES 7'h62
`define CDO_LAST_FRAME 7'h61
`define CDO_S1_FRAME 7'h01
`define CDO_FIRST_Q 7'h02
`define CDO_FIRST_CRC 7'h52
`define CDO_Q_BIT 3'h6
`define CDO_CRC_POLY 16'h1021
`define CDO_SYNC_NS 64'd1000
`define CDO_SYNC_CYC 10'((`CDO_SYNC_NS * `CDO_MCLK_HZ) / 64'd1000000000)
`define CDO_RCLK_NS 64'd500
`define CDO_RCLK_CYC 10'((`CDO_RCLK_NS * `CDO_MCLK_HZ) / 64'd1000000000)
`define CDO_PIN_BCK 0
`define CDO_PIN_CHANNEL_SELECT_CLOCK 1
`define CDO_PIN_SERIAL_AUDIO_OUT 2
`define CDO_PIN_DOUT 3
`define CDO_PIN_UNC 4
`define CDO_PIN_QOK 5
`define CDO_PIN_RCLK 6
`define CDO_PIN_SDAT 7
`define CDO_PIN_FSYN 8
`define CDO_PIN_BSYN 9
`define CDO_NPINS 10
`endif

// ==== cdo_pkg.sv ====
// Types shared by the disc audio and subcode output block.
// Assumes cdo_params.svh sits in the include path.
package cdo_pkg;
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
    logic left_bad;
    logic right_bad;
    logic c2_mode;
  } cdo_sample_t;
  typedef struct packed {
    logic [7:0] pw;
    logic frame_strobe;
    logic block_sync;
  } cdo_subcode_t;
  typedef struct packed {
    logic [1:0] bck_sel;
    logic lr_invert;
    logic lsb_first;
    logic double_speed;
    logic rclk_is_input;
    logic rclk_invert;
    logic irq_en;
  } cdo_cfg_t;
endpackage : cdo_pkg

// ==== cdo_rx_model.sv ====
// Partner model: audio receiver and subcode reader watching the pins.
// Assumes the bench routes every pin to its function and the read clock
// is generated by the block, rising edge active.
`timescale 1ns/1ps
`default_nettype none
module cdo_rx_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Receiver format
  input wire logic lr_inv,
  input wire logic lsb_first,
  input wire logic [9:0] pins,
  // Received data
  output logic word_valid,
  output logic [17:0] word,
  output logic pw_valid,
  output logic [7:0] pw,
  output logic edge_err
);
  logic [9:0] prev;
  logic [15:0] sh;
  logic [15:0] t;
  logic [7:0] sb;
  logic lrl;
  logic bad;
  int k;
  int n;
  int m;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 10'h000;
      lrl <= 1'b0;
      k <= 0;
      m <= 0;
      word_valid <= 1'b0;
      pw_valid <= 1'b0;
      edge_err <= 1'b0;
    end else begin
      prev <= pins;
      word_valid <= 1'b0;
      pw_valid <= 1'b0;
      // Sample on the rising bit clock; data must not move there
      if (pins[0] && !prev[0]) begin
        if (pins[1] != prev[1] || pins[2] != prev[2] || pins[4] != prev[4])
          edge_err <= 1'b1;
        t = sh;
        n = k;
        if (pins[1] != lrl) begin
          word_valid <= 1'b1;
          word <= {lrl ^ lr_inv, bad, sh};
          t = 16'h0000;
          n = 0;
        end
        if (n == 0)
          bad <= pins[4];
        if (n < 16) begin
          if (lsb_first)
            t[n] = pins[2];
          else
            t[15 - n] = pins[2];
        end
        sh <= t;
        k <= n + 1;
        lrl <= pins[1];
      end
      // Frame sync realigns the subcode reader
      if (pins[8] && !prev[8])
        m <= 0;
      else if (pins[6] && !prev[6]) begin
        sb <= {sb[6:0], pins[7]};
        m <= m + 1;
        if (m == 7) begin
          pw_valid <= 1'b1;
          pw <= {sb[6:0], pins[7]};
        end
      end
    end
  end
endmodule : cdo_rx_model
`default_nettype wire

// ==== test_cdo_output.sv ====
// Testbench for the disc audio and subcode output block.
// Assumes cdo_pkg and cdo_rx_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cdo_params.svh"
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module test_cdo_output;
  import cdo_pkg::*;
  logic mclk, rst_b, sample_take, cd_irq, wv, pv, eerr, started, pb, pd;
  cdo_cfg_t cfg;
  cdo_sample_t sample_in;
  cdo_subcode_t sub_in;
  logic [3:0] cd_irq_vector;
  logic [9:0] func_sel, port_out, port_oe, pin_in, pin_out, pin_oe;
  logic [17:0] word;
  logic [7:0] pwr;
  logic [31:0] seed;
  logic [17:0] expq[$];
  logic [7:0] pwq[$];
  int bad_count, checks, eb, ef, nt, fc, bc, fsc, nirq;
  cdo_output cdo_output_i (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
    .sample_in(sample_in), .sample_take(sample_take), .sub_in(sub_in),
    .cd_irq(cd_irq), .cd_irq_vector(cd_irq_vector),
    .pin_func_sel(func_sel), .port_out(port_out), .port_oe(port_oe),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  cdo_rx_model cdo_rx_model_i (.mclk(mclk), .rst_b(rst_b),
    .lr_inv(cfg.lr_invert), .lsb_first(cfg.lsb_first), .pins(pin_out),
    .word_valid(wv), .word(word), .pw_valid(pv), .pw(pwr), .edge_err(eerr));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic rst_with(input cdo_cfg_t c);
    rst_b <= 1'b0;
    cfg <= c;
    started = 1'b0;
    expq.delete();
    pwq.delete();
    eb = c.bck_sel == 2'h1 ? 48 : c.bck_sel == 2'h2 ? 64 : 32;
    ef = 100000000 / (44100 * (c.double_speed + 1));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
  endtask : rst_with
  task automatic wait_takes(input int n);
    int k;
    for (k = 0; k < 60000 && nt < n; k++)
      @(posedge mclk);
    if (nt < n) begin
      bad_count++;
      close_out();
    end
  endtask : wait_takes
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Behavioural model of the stream, compared at every result
  always @(posedge mclk) begin
    pin_in <= 10'(xs());
    pb <= pin_out[0];
    pd <= pin_out[3];
    if (cd_irq)
      nirq++;
    if (pin_out[8])
      fsc++;
    else if (fsc > 0) begin
      `CHK(fsc, 100)
      fsc = 0;
    end
    if (pv) begin
      if (pwq.size() == 0)
        bad_count++;
      else
        `CHK(pwr, pwq.pop_front())
    end
    if (!rst_b) begin
      nt = 0;
      fc = 0;
      bc = 0;
    end else begin
      fc++;
      if (pin_out[0] && !pb)
        bc++;
      // Biphase mark: cell edge at every fall, mid-cell toggle for a one
      if (pin_out[0] != pb)
        `CHK(pin_out[3] != pd, !pin_out[0] || pin_out[2])
      if (sample_take) begin
        if (nt >= 2) begin
          `CHK(bc, eb)
          `CHK(fc >= ef - 1 && fc <= ef + 2, 1'b1)
        end
        nt++;
        fc = 0;
        bc = 0;
        expq.push_back({1'b0, sample_in.c2_mode & sample_in.left_bad,
          sample_in.left});
        expq.push_back({1'b1, sample_in.c2_mode & sample_in.right_bad,
          sample_in.right});
        sample_in <= cdo_sample_t'({xs(), 3'(xs())});
      end
      if (wv) begin
        if (!started && !word[17] && expq.size() > 0)
          started = 1'b1;
        if (started && expq.size() == 0)
          bad_count++;
        else if (started)
          `CHK(word, expq.pop_front())
      end
    end
  end
  initial begin
    rst_b = 1'b0;
    cfg = '0;
    sample_in = '0;
    sub_in = '0;
    func_sel = 10'h3ff;
    port_out = 10'h000;
    port_oe = 10'h000;
    pin_in = 10'h000;
    bad_count = 0;
    checks = 0;
    nirq = 0;
    fsc = 0;
    seed = 32'd12924;
    // Every rate, both polarities, both bit orders, both speeds
    for (int i = 0; i < 4; i++) begin
      rst_with(cdo_cfg_t'({i[1:0], i[0], i[1], i[1], 3'h0}));
      wait_takes(7);
      `CHK(eerr, 1'b0)
    end
    // Two blocks of subcode; interrupt enabled only for the first
    rst_with(cdo_cfg_t'(8'h01));
    repeat (5) @(posedge mclk);
    nirq = 0;
    for (int f = 0; f < 8; f++) begin
      cfg.irq_en <= f < 4;
      sub_in <= {8'(xs()), 1'b1, f % 4 == 0};
      @(posedge mclk);
      pwq.push_back(sub_in.pw);
      sub_in.frame_strobe <= 1'b0;
      repeat (10) @(posedge mclk);
      `CHK(pin_out[9], f % 4 == 1)
      repeat (990) @(posedge mclk);
    end
    `CHK(nirq, 1)
    `CHK(cd_irq_vector, `CDO_IRQ_VECTOR)
    `CHK(pwq.size(), 0)
    // Pin sharing with the general port, read clock both directions
    for (int r = 0; r < 2; r++) begin
      cfg.rclk_is_input <= r[0];
      // Audio pins stay on function so the stream checks keep running
      func_sel <= 10'(xs()) | 10'h01f;
      port_out <= 10'(xs());
      port_oe <= 10'(xs());
      repeat (3) @(posedge mclk);
      `CHK((pin_out ^ port_out) & ~func_sel, 10'h000)
      `CHK(pin_oe, (port_oe & ~func_sel) |
        (func_sel & ~{3'h0, r[0], 6'h00}))
    end
    close_out();
  end
endmodule : test_cdo_output
`default_nettype wire
